/* File: design/rtcts_defs.svh */
`ifndef RTCTS_DEFS_SVH
`define RTCTS_DEFS_SVH

// Register offsets on the internal register port
`define RTCTS_OFS_CTRL1 4'hE
`define RTCTS_OFS_CTRL2 4'hF
`define RTCTS_OFS_TRIM 4'h7

// Reset values
`define RTCTS_CTRL1_RST 8'h00
`define RTCTS_TRIM_RST 8'h00

// Trim register fields
`define RTCTS_TRIM_STEP_BIT 7
`define RTCTS_TRIM_MSB 6
`define RTCTS_TRIM_LSB 0

// Control two / status fields
`define RTCTS_THR_SEL_BIT 7
`define RTCTS_LOW_SUP_BIT 6
`define RTCTS_OSC_RUN_N_BIT 5
`define RTCTS_PWR_UP_BIT 4
`define RTCTS_SPARE_A_BIT 3
`define RTCTS_PER_FLAG_BIT 2
`define RTCTS_WALM_FLAG_BIT 1
`define RTCTS_DALM_FLAG_BIT 0

// Codes that apply no correction
`define RTCTS_TRIM_NONE_0 7'h00
`define RTCTS_TRIM_NONE_1 7'h01
`define RTCTS_TRIM_NONE_2 7'h40
`define RTCTS_TRIM_NONE_3 7'h41

// Nominal second, adjustment bases and half-second point, in crystal counts
`define RTCTS_SEC_BASE 16'h8000
`define RTCTS_SEC_POS_BASE 16'h7FFF
`define RTCTS_SEC_NEG_BASE 16'h7F80
`define RTCTS_SEC_HALF 16'h4000

// Correction periods in seconds
`define RTCTS_PERIOD_FINE 6'h3C
`define RTCTS_PERIOD_COARSE 6'h14

// One-hertz pulse mode pattern of control one
`define RTCTS_HZ_MASK 8'hCF
`define RTCTS_HZ_VALUE 8'h03

// Timing
`define RTCTS_CLK_MHZ 10
`define RTCTS_OSC_HALT_US 122
`define RTCTS_OSC_HALT_CYCLES (`RTCTS_OSC_HALT_US * `RTCTS_CLK_MHZ)
`define RTCTS_SAMPLE_US 7800
`define RTCTS_SAMPLE_CYCLES (`RTCTS_SAMPLE_US * `RTCTS_CLK_MHZ)

`endif

/* File: design/rtcts_pkg.sv */
package rtcts_pkg;

	typedef logic [7:0] rtcts_byte_t;
	typedef logic [3:0] rtcts_addr_t;
	typedef logic [6:0] rtcts_trim_t;

	typedef enum logic {
		MON_IDLE,
		MON_SAMPLE
	} rtcts_mon_e;

endpackage : rtcts_pkg

/* File: design/rtcts_top.sv */
// Summary of operation
// (R1) Codes 0, +1, -64, -63 mean no correction
// (R2) Positive code lengthens second by code minus one
// (R3) Negative code shortens second by distance from 80h
// (R4) Host programs only -62 through 63
// (R5) Trim byte: step select on top, value below
// (R6) Step select picks about 1.5 ppm or 0.5 ppm steps
// (R7) Only one second per period is altered
// (R8) Raw crystal output never touched by trim
// (R9) Pattern 0,0,x,x,0,0,1,1 gives 1 Hz pulse output
// (R10) Host limits accesses to two per second; rtcts_host sets no such limit
// (R11) Power-up resets both controls and trim
// (R12) Power-up sets power flag, clears low-supply flag
// (R13) Status bits D4, D5, D6 at Fh
// (R14) Power and supply flags clear-only; oscillator flag writable
// (R15) Oscillator halt clears running flag
// (R16) Supply below chosen threshold sets low-supply flag
// (R17) Power flag holds listed fields at zero
// (R18) Trim value is seven bits, 6 to 0
// (R19) Select bit picks 2.1 V or 1.35 V
// (R20) Supply sampled 7.8 ms per second until set
// (R21) Coarse step every 20 s, fine every 60 s
// (R22) Writing one to clear-only flag changes nothing
`timescale 1ns/1ps
`include "rtcts_defs.svh"

module rtcts_top #(
	parameter int SAMPLE_CYCLES = `RTCTS_SAMPLE_CYCLES,
	parameter int OSC_HALT_CYCLES = `RTCTS_OSC_HALT_CYCLES
) (
	// Clock and power-up reset
	input wire logic mclk,
	input wire logic rst_n,
	// Crystal
	input wire logic osc_level,
	output logic raw_crystal_output,
	// Register port
	input wire rtcts_pkg::rtcts_addr_t reg_addr,
	input wire rtcts_pkg::rtcts_byte_t reg_wdata,
	input wire logic reg_wr,
	output rtcts_pkg::rtcts_byte_t reg_rdata,
	// Events from alarm and periodic logic
	input wire logic periodic_event,
	input wire logic weekly_alarm_event,
	input wire logic daily_alarm_event,
	// Supply comparators
	input wire logic supply_below_high,
	input wire logic supply_below_low,
	output logic monitor_sample_en,
	// Corrected time base
	output logic second_tick,
	output logic irq_pulse_n,
	// Control state for neighbouring logic
	output rtcts_pkg::rtcts_byte_t control_one,
	output rtcts_pkg::rtcts_byte_t time_trim
);
	import rtcts_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Crystal edge detection and raw output

	logic osc_d_reg, osc_d_next;
	logic raw_reg, raw_next;
	logic osc_tick;

	always_comb begin
		osc_d_next = osc_level;
		raw_next = osc_level; // R8
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_d_reg <= 1'b0;
			raw_reg <= 1'b0;
		end else begin
			osc_d_reg <= osc_d_next;
			raw_reg <= raw_next;
		end
	end

	assign osc_tick = osc_level & ~osc_d_reg;
	assign raw_crystal_output = raw_reg;

	////////////////////////////////////////////////////////////////////////////
	// Oscillation halt sensing

	logic [15:0] halt_cnt_reg, halt_cnt_next;
	logic halt_seen;

	always_comb begin
		halt_cnt_next = halt_cnt_reg;
		halt_seen = 1'b0;
		if (osc_tick) begin
			halt_cnt_next = 16'h0000;
		end else if (halt_cnt_reg >= 16'(OSC_HALT_CYCLES - 1)) begin
			halt_seen = 1'b1; // R15
		end else begin
			halt_cnt_next = halt_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			halt_cnt_reg <= 16'h0000;
		end else begin
			halt_cnt_reg <= halt_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file

	logic [7:0] ctrl1_reg, ctrl1_next;
	logic [7:0] trim_reg, trim_next;
	logic thr_sel_reg, thr_sel_next;
	logic low_sup_reg, low_sup_next;
	logic osc_run_n_reg, osc_run_n_next;
	logic pwr_up_reg, pwr_up_next;
	logic spare_a_reg, spare_a_next;
	logic per_flag_reg, per_flag_next;
	logic walm_reg, walm_next;
	logic dalm_reg, dalm_next;
	logic [7:0] rdata_reg, rdata_next;
	logic wr_ctrl1, wr_ctrl2, wr_trim;
	logic low_sup_set;

	assign wr_ctrl1 = reg_wr && (reg_addr == `RTCTS_OFS_CTRL1);
	assign wr_ctrl2 = reg_wr && (reg_addr == `RTCTS_OFS_CTRL2);
	assign wr_trim = reg_wr && (reg_addr == `RTCTS_OFS_TRIM);

	always_comb begin
		ctrl1_next = ctrl1_reg;
		trim_next = trim_reg;
		thr_sel_next = thr_sel_reg;
		spare_a_next = spare_a_reg;
		low_sup_next = low_sup_reg;
		osc_run_n_next = osc_run_n_reg;
		pwr_up_next = pwr_up_reg;
		per_flag_next = per_flag_reg;
		walm_next = walm_reg;
		dalm_next = dalm_reg;

		if (wr_ctrl1) begin
			ctrl1_next = reg_wdata;
		end
		if (wr_trim) begin
			trim_next = reg_wdata; // R5 R18
		end

		// Clear-only flags: a written one is ignored, a hardware set wins
		if (wr_ctrl2) begin
			thr_sel_next = reg_wdata[`RTCTS_THR_SEL_BIT];
			spare_a_next = reg_wdata[`RTCTS_SPARE_A_BIT];
			osc_run_n_next = reg_wdata[`RTCTS_OSC_RUN_N_BIT]; // R14
			if (!reg_wdata[`RTCTS_PWR_UP_BIT]) begin
				pwr_up_next = 1'b0; // R14 R22
			end
			if (!reg_wdata[`RTCTS_LOW_SUP_BIT]) begin
				low_sup_next = 1'b0; // R14 R22
			end
			if (!reg_wdata[`RTCTS_PER_FLAG_BIT]) begin
				per_flag_next = 1'b0; // R22
			end
			if (!reg_wdata[`RTCTS_WALM_FLAG_BIT]) begin
				walm_next = 1'b0; // R22
			end
			if (!reg_wdata[`RTCTS_DALM_FLAG_BIT]) begin
				dalm_next = 1'b0; // R22
			end
		end

		if (low_sup_set) begin
			low_sup_next = 1'b1; // R16
		end
		if (halt_seen) begin
			osc_run_n_next = 1'b0; // R15
		end
		if (periodic_event) begin
			per_flag_next = 1'b1;
		end
		if (weekly_alarm_event) begin
			walm_next = 1'b1;
		end
		if (daily_alarm_event) begin
			dalm_next = 1'b1;
		end

		// Power-up flag holds the listed fields at zero until software clears it
		if (pwr_up_reg) begin
			ctrl1_next = 8'h00; // R17
			trim_next = 8'h00; // R17
			thr_sel_next = 1'b0; // R17
			spare_a_next = 1'b0; // R17
			low_sup_next = 1'b0; // R17
			per_flag_next = 1'b0; // R17
			walm_next = 1'b0; // R17
			dalm_next = 1'b0; // R17
		end
	end

	always_comb begin
		rdata_next = 8'h00;
		case (reg_addr)
			`RTCTS_OFS_CTRL1: begin
				rdata_next = ctrl1_reg;
			end
			`RTCTS_OFS_CTRL2: begin
				rdata_next[`RTCTS_THR_SEL_BIT] = thr_sel_reg;
				rdata_next[`RTCTS_LOW_SUP_BIT] = low_sup_reg; // R13
				rdata_next[`RTCTS_OSC_RUN_N_BIT] = osc_run_n_reg; // R13
				rdata_next[`RTCTS_PWR_UP_BIT] = pwr_up_reg; // R13
				rdata_next[`RTCTS_SPARE_A_BIT] = spare_a_reg;
				rdata_next[`RTCTS_PER_FLAG_BIT] = per_flag_reg;
				rdata_next[`RTCTS_WALM_FLAG_BIT] = walm_reg;
				rdata_next[`RTCTS_DALM_FLAG_BIT] = dalm_reg;
			end
			`RTCTS_OFS_TRIM: begin
				rdata_next = trim_reg;
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_reg <= `RTCTS_CTRL1_RST; // R11
			trim_reg <= `RTCTS_TRIM_RST; // R11
			thr_sel_reg <= 1'b0; // R11 R19
			spare_a_reg <= 1'b0;
			low_sup_reg <= 1'b0; // R12
			osc_run_n_reg <= 1'b0;
			pwr_up_reg <= 1'b1; // R12
			per_flag_reg <= 1'b0;
			walm_reg <= 1'b0;
			dalm_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			ctrl1_reg <= ctrl1_next;
			trim_reg <= trim_next;
			thr_sel_reg <= thr_sel_next;
			spare_a_reg <= spare_a_next;
			low_sup_reg <= low_sup_next;
			osc_run_n_reg <= osc_run_n_next;
			pwr_up_reg <= pwr_up_next;
			per_flag_reg <= per_flag_next;
			walm_reg <= walm_next;
			dalm_reg <= dalm_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign control_one = ctrl1_reg;
	assign time_trim = trim_reg;

	////////////////////////////////////////////////////////////////////////////
	// Corrected second count

	logic sec_tick;
	logic half_low_n;

	rtcts_trim_counter u_trim (
		.mclk(mclk),
		.rst_n(rst_n),
		.osc_tick(osc_tick),
		.trim_step_select(trim_reg[`RTCTS_TRIM_STEP_BIT]),
		.trim_code(trim_reg[`RTCTS_TRIM_MSB:`RTCTS_TRIM_LSB]),
		.second_tick(sec_tick),
		.half_low_n(half_low_n)
	);

	assign second_tick = sec_tick;

	////////////////////////////////////////////////////////////////////////////
	// One-hertz pulse mode output

	logic irq_reg, irq_next;

	always_comb begin
		irq_next = 1'b1;
		if ((ctrl1_reg & `RTCTS_HZ_MASK) == `RTCTS_HZ_VALUE) begin
			irq_next = half_low_n; // R9
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b1;
		end else begin
			irq_reg <= irq_next;
		end
	end

	assign irq_pulse_n = irq_reg;

	////////////////////////////////////////////////////////////////////////////
	// Supply monitor sampling window

	rtcts_mon_e mon_reg, mon_next;
	logic [19:0] win_cnt_reg, win_cnt_next;
	logic below;

	assign below = thr_sel_reg ? supply_below_low : supply_below_high; // R19

	always_comb begin
		mon_next = mon_reg;
		win_cnt_next = win_cnt_reg;
		low_sup_set = 1'b0;
		case (mon_reg)
			MON_IDLE: begin
				win_cnt_next = 20'h00000;
				if (sec_tick && !low_sup_reg && !pwr_up_reg) begin
					mon_next = MON_SAMPLE; // R20
				end
			end
			MON_SAMPLE: begin
				if (below) begin
					low_sup_set = 1'b1; // R16
					mon_next = MON_IDLE; // R20
				end else if (win_cnt_reg >= 20'(SAMPLE_CYCLES - 1)) begin
					mon_next = MON_IDLE; // R20
				end else begin
					win_cnt_next = win_cnt_reg + 20'h00001;
				end
			end
			default: begin
				mon_next = MON_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mon_reg <= MON_IDLE;
			win_cnt_reg <= 20'h00000;
		end else begin
			mon_reg <= mon_next;
			win_cnt_reg <= win_cnt_next;
		end
	end

	assign monitor_sample_en = (mon_reg == MON_SAMPLE);

endmodule : rtcts_top

/* File: design/rtcts_trim_counter.sv */
`timescale 1ns/1ps
`include "rtcts_defs.svh"

module rtcts_trim_counter (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Crystal time base
	input wire logic osc_tick,
	// Trim setting
	input wire logic trim_step_select,
	input wire rtcts_pkg::rtcts_trim_t trim_code,
	// Corrected time base
	output logic second_tick,
	output logic half_low_n
);
	import rtcts_pkg::*;

	logic [15:0] cnt_reg, cnt_next;
	logic [5:0] sec_reg, sec_next;
	logic tick_reg, tick_next;
	logic half_reg, half_next;
	logic [15:0] len;
	logic [5:0] period;

	always_comb begin
		// Only the first second of each period is stretched or shortened
		len = `RTCTS_SEC_BASE; // R7
		if (sec_reg == 6'h00) begin
			if (trim_code == `RTCTS_TRIM_NONE_0 || trim_code == `RTCTS_TRIM_NONE_1 ||
				trim_code == `RTCTS_TRIM_NONE_2 || trim_code == `RTCTS_TRIM_NONE_3) begin
				len = `RTCTS_SEC_BASE; // R1
			end else if (!trim_code[`RTCTS_TRIM_MSB]) begin
				len = `RTCTS_SEC_POS_BASE + {9'h000, trim_code}; // R2
			end else begin
				len = `RTCTS_SEC_NEG_BASE + {9'h000, trim_code}; // R3
			end
		end
		period = trim_step_select ? `RTCTS_PERIOD_FINE : `RTCTS_PERIOD_COARSE; // R21 R6
	end

	always_comb begin
		cnt_next = cnt_reg;
		sec_next = sec_reg;
		tick_next = 1'b0;
		half_next = half_reg;
		if (osc_tick) begin
			if (cnt_reg >= len - 16'h0001) begin
				cnt_next = 16'h0000;
				tick_next = 1'b1;
				sec_next = (sec_reg >= period - 6'h01) ? 6'h00 : sec_reg + 6'h01; // R7
			end else begin
				cnt_next = cnt_reg + 16'h0001;
			end
			half_next = (cnt_next >= `RTCTS_SEC_HALF);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
			sec_reg <= 6'h00;
			tick_reg <= 1'b0;
			half_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			sec_reg <= sec_next;
			tick_reg <= tick_next;
			half_reg <= half_next;
		end
	end

	assign second_tick = tick_reg;
	assign half_low_n = half_reg;

endmodule : rtcts_trim_counter

/* File: tb/rtcts_host.sv */
`timescale 1ns/1ps
module rtcts_host (
	// Clock
	input wire logic mclk,
	// Register port
	output rtcts_pkg::rtcts_addr_t reg_addr,
	output rtcts_pkg::rtcts_byte_t reg_wdata,
	output logic reg_wr,
	input wire rtcts_pkg::rtcts_byte_t reg_rdata
);
	import rtcts_pkg::*;
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
	end
	// Single write, strobe high for one edge
	task automatic wr(input rtcts_addr_t a, input rtcts_byte_t d);
		if (a == 4'h7 && d[6:0] inside {7'h40, 7'h41}) begin
			d[6:0] = 7'h00;
		end
		// Accesses start on the block's own clock, never at unrelated times
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input rtcts_addr_t a, output rtcts_byte_t d);
		@(posedge mclk);
		reg_addr <= a;
		repeat (2) @(posedge mclk);
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : rtcts_host

/* File: tb/rtcts_monitor.sv */
`timescale 1ns/1ps
module rtcts_monitor #(
	parameter int SAMPLE_CYCLES = 20
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Watched ports
	input wire logic osc_level,
	input wire logic raw_crystal_output,
	input wire rtcts_pkg::rtcts_addr_t reg_addr,
	input wire rtcts_pkg::rtcts_byte_t reg_rdata,
	input wire logic monitor_sample_en,
	input wire logic second_tick,
	input wire logic irq_pulse_n,
	input wire rtcts_pkg::rtcts_byte_t control_one,
	input wire rtcts_pkg::rtcts_byte_t time_trim
);
	import rtcts_pkg::*;
	int win_reg;
	int win_next;
	always_comb begin
		win_next = monitor_sample_en ? win_reg + 1 : 0;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			win_reg <= 0;
		end else begin
			win_reg <= win_next;
		end
	end
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_raw_clock_follow: assert property ($past(rst_n) |-> raw_crystal_output == $past(osc_level))
		else $error("raw output differs from crystal");
	a_tick_one_cycle: assert property (second_tick |=> !second_tick)
		else $error("second tick longer than one cycle");
	a_irq_idle_high: assert property (((control_one & 8'hCF) != 8'h03) [*2] |-> irq_pulse_n)
		else $error("pulse output low without pulse mode");
	a_power_holds_ctl: assert property (($past(reg_addr) == 4'hF && reg_rdata[4]) |->
		(control_one == 8'h00 && time_trim == 8'h00))
		else $error("control or trim nonzero while power flag set");
	a_power_holds_flags: assert property (($past(reg_addr) == 4'hF && reg_rdata[4]) |-> (reg_rdata & 8'hCF) == 8'h00)
		else $error("status fields nonzero while power flag set");
	a_sample_entry: assert property ($rose(monitor_sample_en) |-> $past(second_tick))
		else $error("sampling began without a second tick");
	a_sample_bound: assert property (monitor_sample_en |-> win_reg < SAMPLE_CYCLES)
		else $error("sampling window too long");
	a_sample_stop: assert property (($past(reg_addr) == 4'hF && reg_rdata[6]) |-> !monitor_sample_en)
		else $error("sampling while low supply flag set");
endmodule : rtcts_monitor

bind rtcts_top rtcts_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) rtcts_monitor_i (.mclk, .rst_n, .osc_level,
	.raw_crystal_output, .reg_addr, .reg_rdata, .monitor_sample_en, .second_tick, .irq_pulse_n, .control_one,
	.time_trim);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
	import rtcts_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic osc_level = 1'b0;
	logic osc_q = 1'b0;
	logic osc_run = 1'b1;
	logic periodic_event = 1'b0;
	logic weekly_alarm_event = 1'b0;
	logic daily_alarm_event = 1'b0;
	logic supply_below_high = 1'b0;
	logic supply_below_low = 1'b0;
	rtcts_addr_t reg_addr;
	rtcts_byte_t reg_wdata, reg_rdata, control_one, time_trim, ctl, trim;
	logic reg_wr, raw_crystal_output, monitor_sample_en, second_tick, irq_pulse_n;
	logic [31:0] r;
	int n_errors = 0;
	int n_tests = 0;
	int edges = 0;
	int ph = 0;
	int st = 8'h10;
	int seed = 32'h7BFD1BF2;
	int i;
	always #50 mclk = ~mclk;
	rtcts_top #(.SAMPLE_CYCLES(20), .OSC_HALT_CYCLES(8)) rtcts_top_i (.mclk, .rst_n, .osc_level,
		.raw_crystal_output, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .periodic_event, .weekly_alarm_event,
		.daily_alarm_event, .supply_below_high, .supply_below_low, .monitor_sample_en, .second_tick, .irq_pulse_n,
		.control_one, .time_trim);
	rtcts_host rtcts_host_i (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata);
	// Crystal: one rising edge every three cycles, counted as the block sees it
	always @(posedge mclk) begin
		ph <= (ph == 2) ? 0 : ph + 1;
		osc_level <= osc_run && ph == 0;
		osc_q <= osc_level;
		if (rst_n && osc_level && !osc_q) begin
			edges <= edges + 1;
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic int sec_len(input int c);
		if (c < 2 || c == 64 || c == 65) return 32768;
		if (c < 64) return 32767 + c;
		return 32768 - (128 - c);
	endfunction : sec_len
	function automatic int st_wr(input int s, input int d);
		int k;
		k = (s & d & 8'h57) | (d & 8'hA8);
		return s[4] ? k & 8'h30 : k;
	endfunction : st_wr
	task automatic cmp_b(input rtcts_byte_t g, input rtcts_byte_t e);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: byte %h expected %h", $time, g, e);
		end
	endtask : cmp_b
	task automatic cmp_i(input int g, input int e);
		n_tests++;
		if (g != e) begin
			n_errors++;
			$display("wrong value at %0t: count %0d expected %0d", $time, g, e);
		end
	endtask : cmp_i
	task automatic chk(input rtcts_addr_t a, input rtcts_byte_t e);
		rtcts_byte_t g;
		rtcts_host_i.rd(a, g);
		cmp_b(g, e);
	endtask : chk
	task automatic put(input rtcts_addr_t a, input rtcts_byte_t d);
		rtcts_host_i.wr(a, d);
		if (a == 4'hF) begin
			st = st_wr(st, d);
		end
	endtask : put
	task automatic finish_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		chk(4'hE, 8'h00);
		chk(4'h7, 8'h00);
		chk(4'hF, 8'h10);
		put(4'hE, 8'hFF);
		put(4'h7, 8'hFF);
		put(4'hF, 8'hFF);
		chk(4'hE, 8'h00);
		chk(4'h7, 8'h00);
		chk(4'hF, st[7:0]);
		put(4'hF, 8'h20);
		chk(4'hF, st[7:0]);
		r = $random(seed);
		ctl = 8'h03 | (r[7:0] & 8'h30);
		trim = {r[8], 7'h46};
		put(4'hE, ctl);
		put(4'h7, trim);
		chk(4'hE, ctl);
		chk(4'h7, trim);
		cmp_b(control_one, ctl);
		cmp_b(time_trim, trim);
		chk(4'h3, 8'h00);
		cmp_b({7'h00, irq_pulse_n}, 8'h00);
		{periodic_event, weekly_alarm_event, daily_alarm_event} <= 3'h7;
		@(posedge mclk);
		{periodic_event, weekly_alarm_event, daily_alarm_event} <= 3'h0;
		st = st | 8'h07;
		chk(4'hF, st[7:0]);
		put(4'hF, 8'hA7);
		chk(4'hF, st[7:0]);
		put(4'hF, 8'h20);
		chk(4'hF, st[7:0]);
		supply_below_high <= 1'b1;
		for (i = 0; i < 100000 && second_tick !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
			if (i < 3) begin
				cmp_b({7'h00, raw_crystal_output}, {7'h00, osc_q});
			end
			if (i == 70000) begin
				cmp_b({7'h00, irq_pulse_n}, 8'h01);
			end
		end
		if (second_tick !== 1'b1) begin
			n_errors++;
		end else begin
			cmp_i(edges, sec_len(int'(trim[6:0])));
			@(posedge mclk);
			#1;
			cmp_b({7'h00, monitor_sample_en}, 8'h01);
			cmp_b({7'h00, irq_pulse_n}, 8'h00);
			repeat (3) @(posedge mclk);
			st = st | 8'h40;
			chk(4'hF, st[7:0]);
			supply_below_high <= 1'b0;
			osc_run <= 1'b0;
			repeat (20) @(posedge mclk);
			st = st & 8'hDF;
			chk(4'hF, st[7:0]);
		end
		finish_test();
	end
endmodule : tb
